// ---- hdl/ttsm_pkg.sv ----
// package: constants and types for the tape transport select/motion block
package ttsm_pkg;
  localparam int UNITS_N      = 8;
  localparam int UNIT_W       = 3;
  localparam int DATA_N       = 3;
  localparam int MARK_W       = 6;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] WDATA_OFS  = 8'h08;
  localparam logic [7:0] RDATA_OFS  = 8'h0C;
  localparam logic [7:0] MARK_OFS   = 8'h10;
  // control field positions
  localparam int CTRL_UNIT_LSB = 0;
  localparam int CTRL_REMOTE   = 3;
  localparam int CTRL_WPROT    = 4;
  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [2:0]  DATA_RST  = 3'h0;
  typedef enum logic [1:0] {
    TTSM_IDLE,
    TTSM_FWD,
    TTSM_REV
  } ttsm_motion_t;
endpackage : ttsm_pkg

// ---- hdl/ttsm_sync.sv ----
// module: two-flop synchroniser, edge finder for link-side inputs
`timescale 1ns/100ps
`default_nettype none
module ttsm_sync
#(
  parameter int W = 1
)
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign sync_out = sync_q;
  assign rise     = sync_q & ~prev_q;
  assign fall     = ~sync_q & prev_q;
endmodule // ttsm_sync
`default_nettype wire

// ---- hdl/ttsm_top.sv ----
// module: transport-side select, motion and track logic with AHB-Lite regs
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ttsm_top
(
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic                         hready,
  input  wire logic [31:0]                  hwdata,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire logic [ttsm_pkg::UNITS_N-1:0] select_n,
  input  wire logic                         motion_request,
  input  wire logic                         halt_request,
  input  wire logic                         forward_request,
  input  wire logic                         backward_request,
  input  wire logic                         clock_track,
  input  wire logic                         marker_track,
  input  wire logic [ttsm_pkg::DATA_N-1:0]  data_in,
  output logic      [ttsm_pkg::DATA_N-1:0]  data_out,
  output logic      [ttsm_pkg::DATA_N-1:0]  data_oe_n,
  output logic                              select_echo,
  output logic                              write_echo,
  output logic                              remote_lamp,
  output logic                              forward_run,
  output logic                              reverse_run,
  output logic                              timing_phase_load,
  output logic                              timing_phase_toggle
);
  import ttsm_pkg::*;

  // synchronised link inputs
  logic [UNITS_N-1:0] sel_s;
  logic [3:0]         cmd_s;
  logic               tt_s;
  logic               tt_rise;
  logic               tt_fall;
  logic               mt_s;
  logic [DATA_N-1:0]  din_s;

  ttsm_sync #(.W(UNITS_N)) u_sel
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (~select_n),
    .sync_out (sel_s),
    .rise     (),
    .fall     ()
  );

  ttsm_sync #(.W(4)) u_cmd
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({motion_request, halt_request,
                forward_request, backward_request}),
    .sync_out (cmd_s),
    .rise     (),
    .fall     ()
  );

  ttsm_sync #(.W(1)) u_tt
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (clock_track),
    .sync_out (tt_s),
    .rise     (tt_rise),
    .fall     (tt_fall)
  );

  ttsm_sync #(.W(1 + DATA_N)) u_trk
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({marker_track, data_in}),
    .sync_out ({mt_s, din_s}),
    .rise     (),
    .fall     ()
  );

  logic go_s;
  logic halt_s;
  logic fwd_s;
  logic rev_s;
  assign go_s   = cmd_s[3];
  assign halt_s = cmd_s[2];
  assign fwd_s  = cmd_s[1];
  assign rev_s  = cmd_s[0];

  // software registers
  logic [31:0]       ctrl_q;
  logic [DATA_N-1:0] wdata_q;
  logic [DATA_N-1:0] rdata_q;
  logic [MARK_W-1:0] mark_q;
  logic [UNIT_W-1:0] unit_number_switch;
  logic              remote_sw;
  logic              write_protect_switch;
  assign unit_number_switch   = ctrl_q[CTRL_UNIT_LSB +: UNIT_W];
  assign remote_sw            = ctrl_q[CTRL_REMOTE];
  assign write_protect_switch = ctrl_q[CTRL_WPROT];

  logic address_match;
  assign address_match = sel_s[unit_number_switch];

  logic selected;
  logic head_connect;
  assign selected     = address_match & remote_sw;
  assign head_connect = selected;

  logic write_permit_internal;
  assign write_permit_internal = head_connect & ~write_protect_switch;

  // motion state
  logic         motion_state;
  logic         direction_state;
  ttsm_motion_t mstate_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mstate_q <= TTSM_IDLE;
    else
    begin
      case (mstate_q)
        TTSM_IDLE:
        begin
          if (selected && go_s && !halt_s && fwd_s && !rev_s)
            mstate_q <= TTSM_FWD;
          else if (selected && go_s && !halt_s && rev_s && !fwd_s)
            mstate_q <= TTSM_REV;
        end
        TTSM_FWD, TTSM_REV:
        begin
          if (!go_s || halt_s || !remote_sw)
            mstate_q <= TTSM_IDLE;
          else if (selected && rev_s && !fwd_s)
            mstate_q <= TTSM_REV;
          else if (selected && fwd_s && !rev_s)
            mstate_q <= TTSM_FWD;
        end
        default:
          mstate_q <= TTSM_IDLE;
      endcase
    end
  end

  assign motion_state    = (mstate_q != TTSM_IDLE);
  assign direction_state = (mstate_q == TTSM_FWD);

  // run the reel for the direction of motion, other reel drags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      forward_run <= 1'b0;
      reverse_run <= 1'b0;
    end
    else
    begin
      forward_run <= motion_state & direction_state;
      reverse_run <= motion_state & ~direction_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      select_echo <= 1'b0;
      write_echo  <= 1'b0;
      remote_lamp <= 1'b0;
    end
    else
    begin
      select_echo <= selected;
      write_echo  <= write_permit_internal;
      remote_lamp <= head_connect;
    end
  end

  // timing phases from clock track edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timing_phase_load   <= 1'b0;
      timing_phase_toggle <= 1'b0;
    end
    else
    begin
      timing_phase_load   <= tt_rise;
      timing_phase_toggle <= tt_fall;
    end
  end

  // write buffers; load and toggle
  logic [DATA_N-1:0] wbuf_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wbuf_q <= DATA_RST;
    else if (tt_rise)
      wbuf_q <= wdata_q;
    else if (tt_fall)
      wbuf_q <= ~wbuf_q;
  end

  // head drive per track, only connected and permitted
  genvar gi;
  generate
    for (gi = 0; gi < DATA_N; gi++)
    begin : g_trk
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          data_out[gi]  <= 1'b0;
          data_oe_n[gi] <= 1'b1;
        end
        else
        begin
          data_out[gi]  <= wbuf_q[gi];
          data_oe_n[gi] <= ~(write_permit_internal & motion_state);
        end
      end
    end
  endgenerate

  // read sample on toggle; mark shift
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_q <= DATA_RST;
      mark_q  <= '0;
    end
    else if (tt_fall)
    begin
      if (head_connect)
        rdata_q <= din_s;
      mark_q <= {mark_q[MARK_W-2:0], mt_s};
    end
  end

  // ahb-lite slave, zero wait state
  logic        ph_wr_q;
  logic        ph_rd_q;
  logic [7:0]  ph_addr_q;
  logic        take;
  assign take = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_q   <= 1'b0;
      ph_rd_q   <= 1'b0;
      ph_addr_q <= 8'h00;
    end
    else
    begin
      ph_wr_q   <= take & hwrite;
      ph_rd_q   <= take & ~hwrite;
      ph_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q  <= CTRL_RST;
      wdata_q <= DATA_RST;
    end
    else if (ph_wr_q)
    begin
      if (ph_addr_q == CTRL_OFS)
        ctrl_q <= {27'h0, hwdata[4:0]};
      if (ph_addr_q == WDATA_OFS)
        wdata_q <= hwdata[DATA_N-1:0];
    end
  end

  logic [31:0] rd_mux;
  always_comb
  begin
    case (haddr[7:0])
      CTRL_OFS:  rd_mux = ctrl_q;
      STAT_OFS:  rd_mux = {25'h0, tt_s, mt_s, write_permit_internal,
                           direction_state, motion_state, head_connect,
                           selected};
      WDATA_OFS: rd_mux = {29'h0, wdata_q};
      RDATA_OFS: rd_mux = {29'h0, rdata_q};
      MARK_OFS:  rd_mux = {26'h0, mark_q};
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    // captured at the address phase so it stands in the data phase
    else if (take & ~hwrite)
      hrdata <= rd_mux;
  end

  assign hreadyout = ~ph_rd_q | 1'b1;
  assign hresp     = 1'b0;
endmodule // ttsm_top
`default_nettype wire

// ---- verif/ttsm_props.sv ----
// checker: port-level properties of the transport select/motion block
`timescale 1ns/100ps
`default_nettype none
module ttsm_props
(
  input wire logic                         hclk,
  input wire logic                         hresetn,
  input wire logic [ttsm_pkg::UNITS_N-1:0] select_n,
  input wire logic                         halt_request,
  input wire logic                         clock_track,
  input wire logic                         hreadyout,
  input wire logic                         hresp,
  input wire logic                         select_echo,
  input wire logic                         write_echo,
  input wire logic                         remote_lamp,
  input wire logic                         forward_run,
  input wire logic                         reverse_run,
  input wire logic                         timing_phase_load,
  input wire logic                         timing_phase_toggle
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sel_lamp_a: assert property (select_echo == remote_lamp)
    else $error("remote lamp differs from select echo");
  wr_sel_a: assert property (write_echo |-> select_echo)
    else $error("write echo without select echo");
  line_sel_a: assert property ((&select_n) [*6] |=> !select_echo)
    else $error("select echo with no select line low");
  run_excl_a: assert property (!(forward_run && reverse_run))
    else $error("both reels driven at once");
  run_sel_a: assert property ($rose(forward_run) |-> select_echo)
    else $error("motion started while unselected");
  halt_stop_a: assert property
    (halt_request [*7] |=> !forward_run && !reverse_run)
    else $error("reel still driven under halt");
  tt_load_a: assert property
    ($rose(clock_track) |-> ##[2:6] timing_phase_load)
    else $error("no load phase after track rise");
  tt_flip_a: assert property
    ($fell(clock_track) |-> ##[2:6] timing_phase_toggle)
    else $error("no toggle phase after track fall");
  ph_excl_a: assert property
    (!(timing_phase_load && timing_phase_toggle))
    else $error("both timing phases at once");
  load_once_a: assert property
    (timing_phase_load |=> !timing_phase_load)
    else $error("load phase longer than one cycle");
  bus_ok_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  cover property ($rose(forward_run));
  cover property ($rose(reverse_run));
  cover property ($rose(write_echo));
  cover property (timing_phase_toggle);
endmodule // ttsm_props
`default_nettype wire

// ---- verif/ttsm_ctrl_model.sv ----
// model: tape controller driving command and track lines
`timescale 1ns/100ps
`default_nettype none
module ttsm_ctrl_model
(
  input  wire logic [2:0] unit,
  input  wire logic       sel_on,
  input  wire logic       go,
  input  wire logic       rev,
  input  wire logic       halt,
  input  wire logic       tt_en,
  input  wire logic [2:0] rd_bits,
  output logic      [7:0] select_n,
  output logic            motion_request,
  output logic            halt_request,
  output logic            forward_request,
  output logic            backward_request,
  output logic            clock_track,
  output logic            marker_track,
  output logic      [2:0] data_in
);
  assign select_n = sel_on ? ~(8'h01 << unit) : 8'hFF;
  assign motion_request = go;
  assign halt_request = halt;
  assign forward_request = go & ~rev;
  assign backward_request = go & rev;
  assign data_in = rd_bits;
  initial
  begin
    clock_track = 1'b0;
    marker_track = 1'b0;
    #37;
    forever
    begin
      #160;
      if (tt_en || clock_track)
        clock_track = ~clock_track;
      if (clock_track)
        marker_track = ~marker_track;
    end
  end
endmodule // ttsm_ctrl_model
`default_nettype wire

// ---- verif/tape_transport_select_motion_bench.sv ----
// bench: self-checking run of the transport select/motion block
`timescale 1ns/100ps
`default_nettype none
module tape_transport_select_motion_bench;
  import ttsm_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, seen_v, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, data_in, data_out, data_oe_n, unit, rd_bits, w, u;
  wire         hready;
  logic [7:0]  select_n;
  logic        mreq, hreq, freq, breq, ctk, mtk;
  logic        sel_e, wr_e, lamp, frun, rrun, ph_ld, ph_tg;
  logic        sel_on, go, rev, halt, tt_en, res_v;
  logic [31:0] exp_q[$];
  string       nam_q[$];
  int          failures, checks_done;
  assign hready = hreadyout;
  ttsm_top u_ttsm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .select_n(select_n),
    .motion_request(mreq), .halt_request(hreq), .forward_request(freq),
    .backward_request(breq), .clock_track(ctk), .marker_track(mtk),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .select_echo(sel_e), .write_echo(wr_e), .remote_lamp(lamp),
    .forward_run(frun), .reverse_run(rrun), .timing_phase_load(ph_ld),
    .timing_phase_toggle(ph_tg));
  ttsm_ctrl_model u_ttsm_ctrl_model (.unit(unit), .sel_on(sel_on), .go(go),
    .rev(rev), .halt(halt), .tt_en(tt_en), .rd_bits(rd_bits),
    .select_n(select_n), .motion_request(mreq), .halt_request(hreq),
    .forward_request(freq), .backward_request(breq), .clock_track(ctk),
    .marker_track(mtk), .data_in(data_in));
  task automatic give_verdict();
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic fail_out();
    failures++;
    give_verdict();
  endtask
  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // note the expectation; the watcher below compares it
  task automatic look(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
    nam_q.push_back(nm);
    exp_q.push_back(e);
    seen_v <= s;
    res_v <= 1'b1;
    @(posedge hclk);
    res_v <= 1'b0;
    @(posedge hclk);
  endtask
  always @(posedge hclk)
    if (res_v === 1'b1)
      check(nam_q.pop_front(), seen_v, exp_q.pop_front());
  task automatic rdy();
    int n = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    if (n >= 50)
      fail_out();
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  task automatic rreg(input string nm, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    look(nm, e, rd & m);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge hclk);
  endtask
  // wait for a timing phase pulse, then one more cycle for data_out
  task automatic wait_ph(input logic tog);
    int n = 0;
    do @(negedge hclk); while ((tog ? ph_tg : ph_ld) !== 1'b1 && ++n < 40);
    if (n >= 40)
      fail_out();
    @(negedge hclk);
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial
  begin
    #2000000;
    fail_out();
  end
  initial
  begin
    hresetn = 1'b0;
    {hsel, hwrite, res_v, sel_on, go, rev, halt, tt_en} = 8'h80;
    {haddr, hwdata, htrans, unit, rd_bits} = '0;
    hsize = 3'h2;
    failures = 0;
    checks_done = 0;
    u = 3'($urandom(82));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rreg("ctrl", CTRL_OFS, 32'hFFFFFFFF, CTRL_RST);
    rreg("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    unit <= u;
    sel_on <= 1'b1;
    bus(1'b1, CTRL_OFS, 32'(u) | 32'h8);
    wt(8);
    look("sel_echo", 32'h1, sel_e);
    look("lamp", 32'h1, lamp);
    look("wr_echo", 32'h1, wr_e);
    rreg("stat", STAT_OFS, 32'h13, 32'h13);
    unit <= u + 3'h1;
    go <= 1'b1;
    wt(8);
    look("other_line", 32'h0, {wr_e, sel_e});
    look("go_unsel", 32'h0, {frun, rrun});
    go <= 1'b0;
    unit <= u;
    bus(1'b1, CTRL_OFS, 32'(u));
    wt(8);
    look("local", 32'h0, sel_e);
    bus(1'b1, CTRL_OFS, 32'(u) | 32'h18);
    wt(8);
    look("locked", 32'h1, {wr_e, sel_e});
    bus(1'b1, CTRL_OFS, 32'(u) | 32'h8);
    // run forward, let the tape reach speed
    go <= 1'b1;
    wt(8);
    look("fwd", 32'h2, {frun, rrun});
    rreg("stat_run", STAT_OFS, 32'h1C, 32'h1C);
    w = 3'($urandom);
    bus(1'b1, WDATA_OFS, {29'h0, w});
    tt_en <= 1'b1;
    wait_ph(1'b0);
    look("wr_load", {29'h0, w}, data_out);
    wait_ph(1'b1);
    look("wr_flip", {29'h0, ~w}, data_out);
    look("drive", 32'h0, data_oe_n);
    tt_en <= 1'b0;
    w = 3'($urandom);
    rd_bits <= w;
    bus(1'b1, CTRL_OFS, 32'(u) | 32'h18);
    tt_en <= 1'b1;
    wait_ph(1'b1);
    @(posedge hclk);
    tt_en <= 1'b0;
    rreg("rdata", RDATA_OFS, 32'h7, {29'h0, w});
    bus(1'b0, MARK_OFS, 32'h0);
    look("mark", 32'h1, {31'h0, rd[0] ^ rd[1]});
    // deselect while moving; motion goes on
    unit <= u + 3'h1;
    wt(8);
    look("coast", 32'h2, {frun, rrun});
    unit <= u;
    rev <= 1'b1;
    wt(8);
    look("rev", 32'h1, {frun, rrun});
    halt <= 1'b1;
    wt(8);
    look("halt", 32'h0, {frun, rrun});
    give_verdict();
  end
endmodule // tape_transport_select_motion_bench
bind ttsm_top ttsm_props u_ttsm_props (.hclk(hclk), .hresetn(hresetn),
  .select_n(select_n), .halt_request(halt_request),
  .clock_track(clock_track), .hreadyout(hreadyout), .hresp(hresp),
  .select_echo(select_echo), .write_echo(write_echo),
  .remote_lamp(remote_lamp), .forward_run(forward_run),
  .reverse_run(reverse_run), .timing_phase_load(timing_phase_load),
  .timing_phase_toggle(timing_phase_toggle));
`default_nettype wire
